// [logic/vic_pkg.sv]
// constants, register map and state codes of the vectored interrupt controller
package vic_pkg;
  // apb address width: index times four, top index 16'hfffb
  localparam int          ADDR_W             = 18;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_EDGE_SELECT    = 16'hfff2;
  localparam logic [15:0] IDX_ENABLE_ONE     = 16'hfff3;
  localparam logic [15:0] IDX_ENABLE_TWO     = 16'hfff4;
  localparam logic [15:0] IDX_PENDING_ONE    = 16'hfff6;
  localparam logic [15:0] IDX_PENDING_TWO    = 16'hfff7;
  localparam logic [15:0] IDX_WAKE_PENDING   = 16'hfff9;
  localparam logic [15:0] IDX_EVENT_STATUS   = 16'hfffa;
  localparam logic [15:0] IDX_EVENT_MASK     = 16'hfffb;
  // reset values
  localparam logic [7:0]  RST_EDGE_SELECT    = 8'he0;
  localparam logic [7:0]  RST_ENABLE         = 8'h00;
  localparam logic [7:0]  RST_PENDING_ONE    = 8'h20;
  localparam logic [7:0]  RST_PENDING_TWO    = 8'h00;
  localparam logic [7:0]  RST_WAKE_PENDING   = 8'h00;
  localparam logic [1:0]  RST_EVENT          = 2'h0;
  // fixed-one bits
  localparam logic [7:0]  EDGE_FIXED_ONES    = 8'he0;
  localparam logic [7:0]  PENDING_ONE_FIXED  = 8'h20;
  // field positions, register one
  localparam int          NUM_REQ_PINS       = 5;
  localparam int          NUM_WAKE_PINS      = 8;
  localparam int          B1_WAKE            = 5;
  localparam int          B1_SERIAL_ONE      = 6;
  localparam int          B1_TIMER_A         = 7;
  // field positions, register two
  localparam int          B2_TIMER_B         = 0;
  localparam int          B2_TIMER_C         = 1;
  localparam int          B2_TIMER_FL        = 2;
  localparam int          B2_TIMER_FH        = 3;
  localparam int          B2_TIMER_G         = 4;
  localparam int          B2_SERIAL_TWO      = 5;
  localparam int          B2_CONVERTER       = 6;
  localparam int          B2_DIRECT          = 7;
  // event status bits
  localparam int          EV_ACCEPT          = 0;
  localparam int          EV_BLOCKED         = 1;
  // vectors; source index i maps to vector VEC_FIRST_SRC + i
  localparam int          NUM_SRC            = 17;
  localparam logic [4:0]  VEC_RESET          = 5'h00;
  localparam logic [4:0]  VEC_FIRST_SRC      = 5'h04;
  localparam logic [4:0]  VEC_LAST_SRC       = 5'h14;
  localparam logic [15:0] VEC_RSV_LO         = 16'h0002;
  localparam logic [15:0] VEC_RSV_HI         = 16'h0007;
  // sequencing states
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_FIRST = 3'b010,
    ST_RUN   = 3'b100
  } vic_state_e;
endpackage

// [logic/vic_edge_if.sv]
// carrier between the controller and its pin edge detector
`timescale 1ns/100ps
interface vic_edge_if #(parameter int N = 13);
  logic [N-1:0] pin_level;
  logic [N-1:0] rise_sel;
  logic [N-1:0] edge_pulse;
  modport ctrl (output pin_level, output rise_sel, input edge_pulse);
  modport det  (input pin_level, input rise_sel, output edge_pulse);
endinterface

// [logic/vic_pin_edge.sv]
// synchroniser and selectable edge detector for external request pins
`timescale 1ns/100ps
module vic_pin_edge #(
  parameter int N = 13
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pins and events
  vic_edge_if.det   ep
);
  logic [N-1:0] sync_a;
  logic [N-1:0] sync_b;
  logic [N-1:0] prev;

  // pins idle high so reset to one; no false edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= '1;
      sync_b <= '1;
      prev   <= '1;
    end else begin
      sync_a <= ep.pin_level;
      sync_b <= sync_a;
      prev   <= sync_b;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_edge
      // compare current and previous synced sample
      assign ep.edge_pulse[g] = ep.rise_sel[g] ? (sync_b[g] & ~prev[g]) : (~sync_b[g] & prev[g]);
    end
  endgenerate
endmodule

// [logic/vic_top.sv]
// vectored interrupt controller with apb register access
// Summary of operation
// - after reset every request stays masked until the first instruction completes.
// - thirteen external and twenty internal request inputs are accepted.
// - among pending requests only the highest fixed priority goes to the cpu.
// - global mask set: flags still set, nothing is offered to the cpu.
// - each of five request pins chooses rising or falling edge alone.
// - priority reset, pins 4-8, wake 9, peripherals 10-20; address twice vector.
// - vector addresses 2 to 7 are never produced.
// - pending flag writes only clear: zero clears, one keeps.
// - edge select bits 7 to 5 read one and ignore writes.
// - edge select bit n: zero falling, one rising edge on pin n.
// - selected edge also governs the shared timer and converter pin inputs.
// - accepting an interrupt leaves its flag set until software clears it.
// - pin enable zero blocks, one passes; all enables reset to zero.
// - reset sequencing forces the cpu global mask bit to one.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
module vic_top (
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [vic_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // external request pins
  input  wire logic [4:0]                   req_pin_in,
  input  wire logic [7:0]                   wakeup_pin,
  // internal peripheral events, one-cycle pulses except serial three levels
  input  wire logic                         timer_a_ovf,
  input  wire logic                         serial_unit_one_done,
  input  wire logic                         timer_b_ovf,
  input  wire logic                         timer_c_ovf,
  input  wire logic [1:0]                   timer_fl_ev,
  input  wire logic [1:0]                   timer_fh_ev,
  input  wire logic [1:0]                   timer_g_ev,
  input  wire logic [1:0]                   serial_unit_two_ev,
  input  wire logic [5:0]                   serial_unit_three_req,
  input  wire logic                         converter_done,
  input  wire logic                         direct_xfer_ev,
  // cpu side
  input  wire logic                         cpu_global_mask,
  input  wire logic                         cpu_first_done,
  input  wire logic                         cpu_ack,
  output logic                              cpu_mask_force,
  output logic                              cpu_irq_req,
  output logic      [4:0]                   cpu_vector_num,
  output logic      [15:0]                  cpu_vector_addr,
  // edges forwarded to timer b, c, f and converter trigger
  output logic      [3:0]                   shared_edge_out,
  // summary interrupt
  output logic                              irq_out
);
  localparam int NPIN = vic_pkg::NUM_REQ_PINS + vic_pkg::NUM_WAKE_PINS;

  vic_pkg::vic_state_e state;
  logic [4:0]          edge_sel;
  logic [7:0]          source_enable_one;
  logic [7:0]          source_enable_two;
  logic [7:0]          pending_one;
  logic [7:0]          pending_two;
  logic [7:0]          wake_pending;
  logic [1:0]          event_status;
  logic [1:0]          event_mask;
  logic [7:0]          set_one;
  logic [7:0]          set_two;
  logic [vic_pkg::NUM_SRC-1:0] active;
  logic [4:0]          next_vector;
  logic                any_active;
  logic [15:0]         acc_idx;
  logic                acc_fire;
  logic                wr_fire;
  logic                mapped;
  logic [7:0]          rd_byte;
  logic [1:0]          set_event;

  vic_edge_if #(.N(NPIN)) ep ();

  vic_pin_edge #(.N(NPIN)) u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .ep      (ep)
  );

  assign ep.pin_level = {wakeup_pin, req_pin_in};
  // wake pins are active low, always falling edge
  assign ep.rise_sel  = {{vic_pkg::NUM_WAKE_PINS{1'b0}}, edge_sel};

  // apb decode: one wait state, answer registered
  assign acc_idx  = paddr[17:2];
  assign acc_fire = psel & penable & ~pready;
  assign wr_fire  = psel & penable & pready & pwrite;

  always_comb begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    case (acc_idx)
      vic_pkg::IDX_EDGE_SELECT:  rd_byte = vic_pkg::EDGE_FIXED_ONES | {3'h0, edge_sel};
      vic_pkg::IDX_ENABLE_ONE:   rd_byte = source_enable_one;
      vic_pkg::IDX_ENABLE_TWO:   rd_byte = source_enable_two;
      vic_pkg::IDX_PENDING_ONE:  rd_byte = pending_one | vic_pkg::PENDING_ONE_FIXED;
      vic_pkg::IDX_PENDING_TWO:  rd_byte = pending_two;
      vic_pkg::IDX_WAKE_PENDING: rd_byte = wake_pending;
      vic_pkg::IDX_EVENT_STATUS: rd_byte = {6'h00, event_status};
      vic_pkg::IDX_EVENT_MASK:   rd_byte = {6'h00, event_mask};
      default:                   mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= acc_fire;
      pslverr <= acc_fire & ~mapped;
      prdata  <= (acc_fire & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // writable control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_sel          <= vic_pkg::RST_EDGE_SELECT[4:0];
      source_enable_one <= vic_pkg::RST_ENABLE;
      source_enable_two <= vic_pkg::RST_ENABLE;
      event_mask        <= vic_pkg::RST_EVENT;
    end else if (wr_fire) begin
      if (acc_idx == vic_pkg::IDX_EDGE_SELECT)
        edge_sel <= pwdata[4:0];
      if (acc_idx == vic_pkg::IDX_ENABLE_ONE)
        source_enable_one <= pwdata[7:0];
      if (acc_idx == vic_pkg::IDX_ENABLE_TWO)
        source_enable_two <= pwdata[7:0];
      if (acc_idx == vic_pkg::IDX_EVENT_MASK)
        event_mask <= pwdata[1:0];
    end
  end

  // flag set sources; flags set even while globally masked
  always_comb begin
    set_one = 8'h00;
    set_two = 8'h00;
    set_one[4:0]                   = ep.edge_pulse[4:0];
    set_one[vic_pkg::B1_SERIAL_ONE] = serial_unit_one_done;
    set_one[vic_pkg::B1_TIMER_A]    = timer_a_ovf;
    set_two[vic_pkg::B2_TIMER_B]    = timer_b_ovf;
    set_two[vic_pkg::B2_TIMER_C]    = timer_c_ovf;
    set_two[vic_pkg::B2_TIMER_FL]   = |timer_fl_ev;
    set_two[vic_pkg::B2_TIMER_FH]   = |timer_fh_ev;
    set_two[vic_pkg::B2_TIMER_G]    = |timer_g_ev;
    set_two[vic_pkg::B2_SERIAL_TWO] = |serial_unit_two_ev;
    set_two[vic_pkg::B2_CONVERTER]  = converter_done;
    set_two[vic_pkg::B2_DIRECT]     = direct_xfer_ev;
  end

  // write zero clears, write one keeps; a same-cycle set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_one  <= vic_pkg::RST_PENDING_ONE & ~vic_pkg::PENDING_ONE_FIXED;
      pending_two  <= vic_pkg::RST_PENDING_TWO;
      wake_pending <= vic_pkg::RST_WAKE_PENDING;
    end else begin
      if (wr_fire && acc_idx == vic_pkg::IDX_PENDING_ONE)
        pending_one <= ((pending_one & pwdata[7:0]) | set_one) & ~vic_pkg::PENDING_ONE_FIXED;
      else
        pending_one <= pending_one | set_one;
      if (wr_fire && acc_idx == vic_pkg::IDX_PENDING_TWO)
        pending_two <= (pending_two & pwdata[7:0]) | set_two;
      else
        pending_two <= pending_two | set_two;
      if (wr_fire && acc_idx == vic_pkg::IDX_WAKE_PENDING)
        wake_pending <= (wake_pending & pwdata[7:0]) | ep.edge_pulse[NPIN-1:5];
      else
        wake_pending <= wake_pending | ep.edge_pulse[NPIN-1:5];
    end
  end

  // gated sources in priority order, index 0 highest
  always_comb begin
    active     = '0;
    active[4:0] = pending_one[4:0] & source_enable_one[4:0];
    active[5]  = (|wake_pending) & source_enable_one[vic_pkg::B1_WAKE];
    active[6]  = pending_one[vic_pkg::B1_SERIAL_ONE] & source_enable_one[vic_pkg::B1_SERIAL_ONE];
    active[7]  = pending_one[vic_pkg::B1_TIMER_A] & source_enable_one[vic_pkg::B1_TIMER_A];
    active[8]  = pending_two[vic_pkg::B2_TIMER_B] & source_enable_two[vic_pkg::B2_TIMER_B];
    active[9]  = pending_two[vic_pkg::B2_TIMER_C] & source_enable_two[vic_pkg::B2_TIMER_C];
    active[10] = pending_two[vic_pkg::B2_TIMER_FL] & source_enable_two[vic_pkg::B2_TIMER_FL];
    active[11] = pending_two[vic_pkg::B2_TIMER_FH] & source_enable_two[vic_pkg::B2_TIMER_FH];
    active[12] = pending_two[vic_pkg::B2_TIMER_G] & source_enable_two[vic_pkg::B2_TIMER_G];
    active[13] = pending_two[vic_pkg::B2_SERIAL_TWO] & source_enable_two[vic_pkg::B2_SERIAL_TWO];
    // serial three gates its own requests
    active[14] = |serial_unit_three_req;
    active[15] = pending_two[vic_pkg::B2_CONVERTER] & source_enable_two[vic_pkg::B2_CONVERTER];
    active[16] = pending_two[vic_pkg::B2_DIRECT] & source_enable_two[vic_pkg::B2_DIRECT];
  end

  always_comb begin
    any_active  = 1'b0;
    next_vector = vic_pkg::VEC_RESET;
    for (int i = vic_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (active[i]) begin
        any_active  = 1'b1;
        next_vector = vic_pkg::VEC_FIRST_SRC + 5'(i);
      end
    end
  end

  // reset vector, then hold off until first instruction done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= vic_pkg::ST_RESET;
    end else begin
      case (state)
        vic_pkg::ST_RESET: state <= vic_pkg::ST_FIRST;
        vic_pkg::ST_FIRST: if (cpu_first_done) begin
          state <= vic_pkg::ST_RUN;
        end
        vic_pkg::ST_RUN:   state <= vic_pkg::ST_RUN;
        default:           state <= vic_pkg::ST_RESET;
      endcase
    end
  end

  // cpu request and vector, registered; address only from the vector table
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_mask_force  <= 1'b1;
      cpu_irq_req     <= 1'b0;
      cpu_vector_num  <= vic_pkg::VEC_RESET;
      cpu_vector_addr <= 16'h0000;
    end else begin
      cpu_mask_force  <= (state == vic_pkg::ST_RESET);
      cpu_irq_req     <= (state == vic_pkg::ST_RUN) & ~cpu_global_mask & any_active;
      cpu_vector_num  <= next_vector;
      cpu_vector_addr <= {10'h000, next_vector, 1'b0};
    end
  end

  // forwarded shared-pin edges follow the selected polarity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      shared_edge_out <= 4'h0;
    else
      shared_edge_out <= ep.edge_pulse[4:1];
  end

  // sticky events, write one clears, set wins
  assign set_event[vic_pkg::EV_ACCEPT]  = cpu_ack & cpu_irq_req;
  assign set_event[vic_pkg::EV_BLOCKED] = cpu_global_mask & any_active & (state == vic_pkg::ST_RUN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_status <= vic_pkg::RST_EVENT;
      irq_out      <= 1'b0;
    end else begin
      if (wr_fire && acc_idx == vic_pkg::IDX_EVENT_STATUS)
        event_status <= (event_status & ~pwdata[1:0]) | set_event;
      else
        event_status <= event_status | set_event;
      irq_out <= |(event_status & event_mask);
    end
  end

  // checks
  startup_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state != vic_pkg::ST_RUN) |=> !cpu_irq_req) else $error("request before first instruction");
  global_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_global_mask |=> !cpu_irq_req) else $error("request offered while globally masked");
  flag_when_masked_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ep.edge_pulse[0] && cpu_global_mask) |=> pending_one[0]) else $error("flag lost under mask");
  rise_detect_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(req_pin_in[0]) && edge_sel[0]) ##1 edge_sel[0] [*2] |=> pending_one[0])
    else $error("rising edge not flagged");
  top_priority_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == vic_pkg::ST_RUN && !cpu_global_mask && active[0]) |=> (cpu_irq_req && cpu_vector_num == 5'h04))
    else $error("highest source not chosen");
  vec_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_irq_req |-> (cpu_vector_addr == {10'h000, cpu_vector_num, 1'b0} &&
    cpu_vector_num >= vic_pkg::VEC_FIRST_SRC && cpu_vector_num <= vic_pkg::VEC_LAST_SRC))
    else $error("vector address wrong");
  no_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(cpu_vector_addr >= vic_pkg::VEC_RSV_LO && cpu_vector_addr <= vic_pkg::VEC_RSV_HI))
    else $error("reserved vector address");
  clear_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_fire && acc_idx == vic_pkg::IDX_PENDING_TWO) |=>
    ((pending_two & $past(pending_two) & $past(pwdata[7:0])) == ($past(pending_two) & $past(pwdata[7:0]))))
    else $error("write of one changed a flag");
  edge_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    (acc_fire && !pwrite && acc_idx == vic_pkg::IDX_EDGE_SELECT) |=> (pready && prdata[7:5] == 3'h7))
    else $error("edge select top bits not one");
  no_auto_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (pending_one[0] && cpu_ack && !(wr_fire && acc_idx == vic_pkg::IDX_PENDING_ONE)) |=> pending_one[0])
    else $error("flag cleared by acceptance");
  enable_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cpu_irq_req && cpu_vector_num == 5'h04) |-> ($past(pending_one[0]) && $past(source_enable_one[0])))
    else $error("disabled pin reached cpu");
  reset_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == vic_pkg::ST_RESET) |=> cpu_mask_force) else $error("mask not forced at reset");

  pin_taken_c: cover property (@(posedge pclk) disable iff (!presetn)
    cpu_irq_req && cpu_vector_num == 5'h04 && cpu_ack);
  wake_taken_c: cover property (@(posedge pclk) disable iff (!presetn)
    cpu_irq_req && cpu_vector_num == 5'h09);
  blocked_c: cover property (@(posedge pclk) disable iff (!presetn)
    cpu_global_mask && any_active && state == vic_pkg::ST_RUN);
  irq_c: cover property (@(posedge pclk) disable iff (!presetn) irq_out);
endmodule

// [test/vic_cpu_model.sv]
// cpu core stand-in: global mask bit, first instruction and acknowledge
`timescale 1ns/100ps
module vic_cpu_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // controller side
  input  wire logic cpu_mask_force,
  input  wire logic cpu_irq_req,
  output logic      cpu_global_mask,
  output logic      cpu_first_done,
  output logic      cpu_ack,
  // bench control of the mask bit
  input  wire logic hold_mask
);
  logic [1:0] boot_cnt;

  // first instruction loads the stack pointer before software may unmask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_cnt        <= 2'h0;
      cpu_first_done  <= 1'b0;
      cpu_global_mask <= 1'b1;
    end else if (cpu_mask_force) begin
      cpu_global_mask <= 1'b1;
    end else begin
      if (boot_cnt != 2'h3) begin
        boot_cnt <= boot_cnt + 2'h1;
      end
      cpu_first_done <= (boot_cnt == 2'h3);
      if (cpu_first_done) begin
        cpu_global_mask <= hold_mask;
      end
    end
  end

  // acknowledge pulses while a request stands unmasked; never clears a flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ack <= 1'b0;
    end else begin
      cpu_ack <= cpu_irq_req && !cpu_ack && !cpu_global_mask;
    end
  end
endmodule

// [test/vic_tb_top.sv]
// self-checking bench for the vectored interrupt controller
`timescale 1ns/100ps
module vic_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, hold_mask;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [4:0]  req_pin_in, r5, cpu_vector_num;
  logic [7:0]  wakeup_pin;
  logic [9:0]  pulse;
  logic [1:0]  grp;
  logic [3:0]  shared_edge, shared_seen = 4'h0;
  logic [15:0] cpu_vector_addr;
  logic        cpu_mask_force, cpu_irq_req, irq_out, cpu_global_mask, cpu_first_done, cpu_ack, e;
  int          fail_count, n_compared, cycles, m_p1, m_p2, m_en1, m_en2, m_wk;
  logic [15:0] ridx [6] = '{vic_pkg::IDX_EDGE_SELECT, vic_pkg::IDX_ENABLE_ONE, vic_pkg::IDX_ENABLE_TWO,
                            vic_pkg::IDX_PENDING_ONE, vic_pkg::IDX_PENDING_TWO, vic_pkg::IDX_WAKE_PENDING};
  logic [7:0]  rrst [6] = '{8'he0, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00};

  vic_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_pin_in(req_pin_in), .wakeup_pin(wakeup_pin), .serial_unit_one_done(pulse[0]),
    .timer_a_ovf(pulse[1]), .timer_b_ovf(pulse[2]), .timer_c_ovf(pulse[3]),
    .timer_fl_ev(pulse[4] ? grp : 2'h0), .timer_fh_ev(pulse[5] ? grp : 2'h0),
    .timer_g_ev(pulse[6] ? grp : 2'h0), .serial_unit_two_ev(pulse[7] ? grp : 2'h0),
    .serial_unit_three_req(6'h00), .converter_done(pulse[8]), .direct_xfer_ev(pulse[9]),
    .cpu_global_mask(cpu_global_mask), .cpu_first_done(cpu_first_done), .cpu_ack(cpu_ack),
    .cpu_mask_force(cpu_mask_force), .cpu_irq_req(cpu_irq_req), .cpu_vector_num(cpu_vector_num),
    .cpu_vector_addr(cpu_vector_addr), .shared_edge_out(shared_edge), .irq_out(irq_out));

  vic_cpu_model cpu_u (.pclk(pclk), .presetn(presetn), .cpu_mask_force(cpu_mask_force),
    .cpu_irq_req(cpu_irq_req), .cpu_global_mask(cpu_global_mask), .cpu_first_done(cpu_first_done),
    .cpu_ack(cpu_ack), .hold_mask(hold_mask));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard: whole run needs a few hundred cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  // collects every forwarded shared-pin edge since reset
  always @(posedge pclk) if (presetn === 1'b1) shared_seen <= shared_seen | shared_edge;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // master holds the request until pready is sampled high at a rising edge
  task automatic apb(input logic wr_en, input logic [15:0] idx, input logic [7:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00, r, e);
    chk(r, {24'h0, exp}, "read data");
    chk({31'h0, e}, 32'h0, "slave error");
  endtask

  // fixed priority over flags and enables, lowest vector wins
  function automatic int exp_vec();
    for (int b = 0; b < 5; b++) if (m_p1[b] && m_en1[b]) return 4 + b;
    if (m_wk != 0 && m_en1[5]) return 9;
    for (int k = 0; k < 10; k++) begin
      if (k < 2 ? (m_p1[6+k] && m_en1[6+k]) : (m_p2[k-2] && m_en2[k-2])) return k < 8 ? 10 + k : 11 + k;
    end
    return 0;
  endfunction

  task automatic chk_out();
    int v;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    v = exp_vec();
    chk({31'h0, cpu_irq_req}, 32'(v != 0), "request");
    chk({27'h0, cpu_vector_num}, 32'(v), "vector");
    chk({16'h0, cpu_vector_addr}, 32'(2 * v), "vector address");
  endtask

  initial begin
    {presetn, psel, penable, pwrite, hold_mask} = 5'h00;
    paddr = '0;
    pwdata = '0;
    req_pin_in = 5'h1f;
    wakeup_pin = 8'hff;
    pulse = '0;
    grp = 2'h1;
    {fail_count, n_compared, cycles, m_p1, m_p2, m_en1, m_en2, m_wk} = '0;
    void'($urandom(32'h7e6ab73f));
    repeat (19) @(posedge pclk);
    @(negedge pclk);
    chk({31'h0, cpu_mask_force}, 32'h1, "mask force in reset");
    chk({31'h0, cpu_irq_req}, 32'h0, "request in reset");
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    for (int i = 0; i < 6; i++) rd_chk(ridx[i], rrst[i]);
    apb(1'b0, 16'hfff5, 8'h00, r, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(r, 32'h0, "unmapped data");
    wr(vic_pkg::IDX_EDGE_SELECT, 8'h1f);
    rd_chk(vic_pkg::IDX_EDGE_SELECT, 8'hff);
    wr(vic_pkg::IDX_EDGE_SELECT, 8'h00);
    rd_chk(vic_pkg::IDX_EDGE_SELECT, 8'he0);
    r5 = 5'($urandom);
    wr(vic_pkg::IDX_EDGE_SELECT, {3'b000, r5});
    rd_chk(vic_pkg::IDX_EDGE_SELECT, {3'b111, r5});
    // opposite edge first on pins set for rising, falling pins stay high; then the selected one
    req_pin_in <= ~r5;
    repeat (6) @(posedge pclk);
    rd_chk(vic_pkg::IDX_PENDING_ONE, 8'h20);
    chk({28'h0, shared_seen}, 32'h0, "shared edges");
    req_pin_in <= r5;
    repeat (6) @(posedge pclk);
    m_p1 = 8'h3f;
    rd_chk(vic_pkg::IDX_PENDING_ONE, 8'h3f);
    chk({28'h0, shared_seen}, 32'hf, "shared edges");
    chk_out();
    wr(vic_pkg::IDX_ENABLE_ONE, 8'h1f);
    m_en1 = 8'h1f;
    for (int p = 0; p < 5; p++) begin
      chk_out();
      wr(vic_pkg::IDX_PENDING_ONE, 8'(~(8'h01 << p)));
      m_p1 &= ~(1 << p);
    end
    rd_chk(vic_pkg::IDX_PENDING_ONE, 8'h20);
    wr(vic_pkg::IDX_ENABLE_ONE, 8'h20);
    m_en1 = 8'h20;
    wakeup_pin <= 8'hf7;
    m_wk = 1;
    // wake flag needs three edges through the synchroniser
    repeat (3) @(posedge pclk);
    chk_out();
    rd_chk(vic_pkg::IDX_WAKE_PENDING, 8'h08);
    wakeup_pin <= 8'hff;
    wr(vic_pkg::IDX_WAKE_PENDING, 8'h00);
    m_wk = 0;
    chk_out();
    // every peripheral source except serial three at once while the cpu is masked
    hold_mask <= 1'b1;
    wr(vic_pkg::IDX_EVENT_MASK, 8'h03);
    wr(vic_pkg::IDX_ENABLE_ONE, 8'hc0);
    wr(vic_pkg::IDX_ENABLE_TWO, 8'hff);
    {m_en1, m_en2} = {32'hc0, 32'hff};
    // pins and edge select both flip, so every pin flags under the mask
    wr(vic_pkg::IDX_EDGE_SELECT, {3'b000, ~r5});
    grp <= 2'h1 + 2'($urandom % 3);
    pulse <= 10'h3ff;
    req_pin_in <= ~r5;
    @(posedge pclk);
    pulse <= 10'h000;
    {m_p1, m_p2} = {32'hff, 32'hff};
    rd_chk(vic_pkg::IDX_PENDING_ONE, 8'hff);
    rd_chk(vic_pkg::IDX_PENDING_TWO, 8'hff);
    @(negedge pclk);
    chk({31'h0, cpu_irq_req}, 32'h0, "masked request");
    chk({31'h0, irq_out}, 32'h1, "blocked event");
    hold_mask <= 1'b0;
    for (int k = 0; k < 10; k++) begin
      chk_out();
      repeat (4) @(posedge pclk);
      if (k < 2) begin
        rd_chk(vic_pkg::IDX_PENDING_ONE, 8'(m_p1));
        wr(vic_pkg::IDX_PENDING_ONE, 8'(~(8'h01 << (6 + k))));
        m_p1 &= ~(1 << (6 + k));
      end else begin
        rd_chk(vic_pkg::IDX_PENDING_TWO, 8'(m_p2));
        wr(vic_pkg::IDX_PENDING_TWO, 8'(~(8'h01 << (k - 2))));
        m_p2 &= ~(1 << (k - 2));
      end
    end
    chk_out();
    apb(1'b0, vic_pkg::IDX_EVENT_STATUS, 8'h00, r, e);
    chk(r, 32'h3, "event status");
    wr(vic_pkg::IDX_EVENT_MASK, 8'h00);
    repeat (2) @(negedge pclk);
    chk({31'h0, irq_out}, 32'h0, "masked summary");
    wr(vic_pkg::IDX_EVENT_MASK, 8'h03);
    wr(vic_pkg::IDX_EVENT_STATUS, 8'h03);
    rd_chk(vic_pkg::IDX_EVENT_STATUS, 8'h00);
    @(negedge pclk);
    chk({31'h0, irq_out}, 32'h0, "cleared summary");
    conclude();
  end
endmodule
